// ===== logic/fec_pkg.sv
// Purpose: Constants and types shared by the frequency and event counter
// Assumes: 100 MHz system clock
// Notes: Times are in ns; cycle counts derive from them
package fec_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NUM_DIGITS = 8;
    localparam int unsigned DIGIT_W = 4;
    localparam int unsigned COUNT_W = NUM_DIGITS * DIGIT_W;
    localparam longint unsigned GATE_SHORT_NS = 64'd100000000;
    localparam longint unsigned GATE_MID_NS = 64'd1000000000;
    localparam longint unsigned GATE_LONG_NS = 64'd10000000000;
    localparam longint unsigned GATE_SHORT_CYC = GATE_SHORT_NS / CLK_PERIOD_NS;
    localparam longint unsigned GATE_MID_CYC = GATE_MID_NS / CLK_PERIOD_NS;
    localparam longint unsigned GATE_LONG_CYC = GATE_LONG_NS / CLK_PERIOD_NS;
    // Digits dropped so the reading lands in kHz: 0.1 s -> 2, 1 s -> 3, 10 s -> 4
    localparam logic [2:0] SHIFT_SHORT = 3'h2;
    localparam logic [2:0] SHIFT_MID = 3'h3;
    localparam logic [2:0] SHIFT_LONG = 3'h4;
    localparam logic [1:0] SEL_EVENT = 2'h0;
    localparam logic [1:0] SEL_SHORT = 2'h1;
    localparam logic [1:0] SEL_MID = 2'h2;
    localparam logic [1:0] SEL_LONG = 2'h3;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [6:0] SEG_BLANK = 7'h00;
    typedef enum logic [1:0] {FEC_IDLE, FEC_GATE, FEC_LATCH} fec_state_type;
endpackage

// ===== logic/fec_bcd_counter.sv
// Purpose: Multi-digit decimal counter with overflow flag
// Assumes: Increment is one cycle wide
// Notes: Wraps to zero past all nines and raises overflow
`timescale 1ns/10ps
module fec_bcd_counter #(
    parameter int unsigned DIGITS = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_inc,
    output logic [4*DIGITS-1:0] o_value,
    output logic o_overflow
);
    initial begin
        if (DIGITS < 1) begin
            $error("DIGITS must be at least one");
        end
    end

    logic [4*DIGITS-1:0] next_value;
    logic carry;

    always_comb begin
        next_value = o_value;
        carry = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (carry) begin
                if (o_value[4*i +: 4] == fec_pkg::DIGIT_MAX) begin
                    next_value[4*i +: 4] = 4'h0;
                end else begin
                    next_value[4*i +: 4] = o_value[4*i +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_value <= '0;
            o_overflow <= 1'b0;
        end else if (i_clear) begin
            o_value <= '0;
            o_overflow <= 1'b0;
        end else if (i_inc) begin
            o_value <= next_value;
            if (carry) begin
                o_overflow <= 1'b1;
            end
        end
    end

    chk_ovf_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_inc && !i_clear && o_value == {DIGITS{fec_pkg::DIGIT_MAX}} |=> o_overflow && o_value == '0)
        else $error("Overflow not raised past all nines");
endmodule // fec_bcd_counter

// ===== logic/fec_counter.sv
// Purpose: Eight-digit frequency and event counter with display drive
// Assumes: Count input is well below half the system clock after sync
// Notes: Display scanned one digit at a time, common segment bus
`timescale 1ns/10ps
module fec_counter #(
    parameter longint unsigned GATE_SHORT = fec_pkg::GATE_SHORT_CYC,
    parameter longint unsigned GATE_MID = fec_pkg::GATE_MID_CYC,
    parameter longint unsigned GATE_LONG = fec_pkg::GATE_LONG_CYC,
    parameter int unsigned SCAN_CYC = 1000
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_count_in,
    input wire logic i_count_gate,
    input wire logic i_reset_button,
    input wire logic [1:0] i_mode_sel,
    output logic o_freq_mode_indicator,
    output logic o_event_indicator,
    output logic o_overflow_indicator,
    output logic [6:0] o_segments,
    output logic [7:0] o_digit_select
);
    localparam int unsigned CW = fec_pkg::COUNT_W;

    initial begin
        if (GATE_SHORT < 2 || GATE_MID < 2 || GATE_LONG < 2 || SCAN_CYC < 1) begin
            $error("Gate and scan counts too small");
        end
        // Gate counter is 40 bits, scan counter 16 bits
        if (GATE_SHORT > 64'hffffffffff || GATE_MID > 64'hffffffffff || GATE_LONG > 64'hffffffffff) begin
            $error("Gate count too large");
        end
        if (SCAN_CYC > 32'h10000) begin
            $error("Scan count too large");
        end
    end

    function automatic logic [6:0] seg_of(input logic [3:0] d);
        logic [6:0] s;
        s = fec_pkg::SEG_BLANK;
        unique case (d)
            4'h0: s = 7'h3f;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;
            default: s = fec_pkg::SEG_BLANK;
        endcase
        return s;
    endfunction

    // Two-stage synchronisers for the panel and pulse inputs
    logic [1:0] in_s, gate_s, btn_s, mode0_s, mode1_s;
    logic in_prev, btn_prev;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            in_s <= 2'h0;
            gate_s <= 2'h0;
            btn_s <= 2'h0;
            mode0_s <= 2'h0;
            mode1_s <= 2'h0;
            in_prev <= 1'b0;
            btn_prev <= 1'b0;
        end else begin
            in_s <= {in_s[0], i_count_in};
            gate_s <= {gate_s[0], i_count_gate};
            btn_s <= {btn_s[0], i_reset_button};
            mode0_s <= {mode0_s[0], i_mode_sel[0]};
            mode1_s <= {mode1_s[0], i_mode_sel[1]};
            in_prev <= in_s[1];
            btn_prev <= btn_s[1];
        end
    end

    logic [1:0] mode_raw, mode_seen, mode;
    logic rise, gated_rise, btn_press, event_mode;
    assign mode_raw = {mode1_s[1], mode0_s[1]};
    // Bits synced apart may skew; take a selection only once it holds two cycles
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_seen <= fec_pkg::SEL_EVENT;
            mode <= fec_pkg::SEL_EVENT;
        end else begin
            mode_seen <= mode_raw;
            if (mode_raw == mode_seen) begin
                mode <= mode_seen;
            end
        end
    end
    assign event_mode = (mode == fec_pkg::SEL_EVENT);
    assign rise = in_s[1] & ~in_prev;
    assign gated_rise = rise & gate_s[1];
    assign btn_press = btn_s[1] & ~btn_prev;

    // Gate sequencer; a mode change restarts the interval
    fec_pkg::fec_state_type state;
    logic [39:0] gate_cnt, gate_len;
    logic [2:0] shift;
    logic [1:0] mode_prev;
    logic mode_change, cnt_clear;
    assign mode_change = (mode != mode_prev);

    always_comb begin
        gate_len = 40'(GATE_SHORT);
        shift = fec_pkg::SHIFT_SHORT;
        unique case (mode)
            fec_pkg::SEL_MID: begin
                gate_len = 40'(GATE_MID);
                shift = fec_pkg::SHIFT_MID;
            end
            fec_pkg::SEL_LONG: begin
                gate_len = 40'(GATE_LONG);
                shift = fec_pkg::SHIFT_LONG;
            end
            default: begin
                gate_len = 40'(GATE_SHORT);
                shift = fec_pkg::SHIFT_SHORT;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= fec_pkg::FEC_IDLE;
            gate_cnt <= 40'h0;
            mode_prev <= fec_pkg::SEL_EVENT;
        end else begin
            mode_prev <= mode;
            unique case (state)
                fec_pkg::FEC_IDLE: begin
                    gate_cnt <= 40'h0;
                    if (!event_mode && !mode_change) begin
                        state <= fec_pkg::FEC_GATE;
                    end
                end
                fec_pkg::FEC_GATE: begin
                    if (event_mode || mode_change) begin
                        state <= fec_pkg::FEC_IDLE;
                    end else if (gate_cnt == gate_len - 40'h1) begin
                        state <= fec_pkg::FEC_LATCH;
                    end
                    gate_cnt <= gate_cnt + 40'h1;
                end
                fec_pkg::FEC_LATCH: begin
                    state <= fec_pkg::FEC_IDLE;
                end
            endcase
        end
    end

    // Clear at gate start, on event-mode button, or on mode change
    assign cnt_clear = (state == fec_pkg::FEC_IDLE && !event_mode)
        || (event_mode && btn_press)
        || mode_change;

    logic [CW-1:0] count;
    logic cnt_ovf;
    logic cnt_inc;
    // In frequency mode edges count only inside the gate
    assign cnt_inc = gated_rise && (event_mode || state == fec_pkg::FEC_GATE);

    fec_bcd_counter #(
        .DIGITS(fec_pkg::NUM_DIGITS)
    ) u_count (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clear(cnt_clear),
        .i_inc(cnt_inc),
        .o_value(count),
        .o_overflow(cnt_ovf)
    );

    // Shown value: live total in event mode, held reading otherwise
    logic [CW-1:0] shown;
    logic show_ovf;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shown <= '0;
            show_ovf <= 1'b0;
        end else if (event_mode) begin
            shown <= count;
            show_ovf <= cnt_ovf;
        end else if (state == fec_pkg::FEC_LATCH) begin
            // Right shift by whole digits turns edges per gate into kHz
            shown <= count >> (4 * shift);
            show_ovf <= cnt_ovf;
        end else if (mode_change) begin
            show_ovf <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_freq_mode_indicator <= 1'b0;
            o_event_indicator <= 1'b0;
            o_overflow_indicator <= 1'b0;
        end else begin
            o_freq_mode_indicator <= !event_mode;
            o_event_indicator <= event_mode;
            o_overflow_indicator <= show_ovf;
        end
    end

    // Display scan, one digit per SCAN_CYC cycles
    logic [15:0] scan_cnt;
    logic [2:0] digit_idx;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            scan_cnt <= 16'h0;
            digit_idx <= 3'h0;
            o_segments <= fec_pkg::SEG_BLANK;
            o_digit_select <= 8'h00;
        end else begin
            if (scan_cnt == 16'(SCAN_CYC - 1)) begin
                scan_cnt <= 16'h0;
                digit_idx <= digit_idx + 3'h1;
            end else begin
                scan_cnt <= scan_cnt + 16'h1;
            end
            o_segments <= seg_of(shown[4*digit_idx +: 4]);
            o_digit_select <= 8'h01 << digit_idx;
        end
    end

    // Checks
    sequence s_gate_end;
        state == fec_pkg::FEC_LATCH;
    endsequence

    chk_latch_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_gate_end |=> state == fec_pkg::FEC_IDLE)
        else $error("Latch did not return to idle");
    chk_freq_ind: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ##1 o_freq_mode_indicator == !$past(event_mode))
        else $error("kHz indicator wrong");
    chk_event_ind: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_event_indicator != o_freq_mode_indicator)
        else $error("Indicators not exclusive");
    chk_gate_blocks: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !gate_s[1] |-> !cnt_inc)
        else $error("Counted while gated off");
    chk_button_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        event_mode && btn_press |=> count == '0)
        else $error("Button did not clear count");
    chk_event_count: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(event_mode) |-> shown == $past(count))
        else $error("Event total not shown");
    chk_ovf_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cnt_clear |=> !cnt_ovf)
        else $error("Overflow not cleared");
    chk_gate_len: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state == fec_pkg::FEC_GATE && !mode_change |-> gate_cnt < gate_len)
        else $error("Gate ran past its length");
    chk_digit_valid: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_digit_select != 8'h00 |-> $onehot(o_digit_select))
        else $error("Digit select not one-hot");
endmodule // fec_counter

// ===== bench/fec_pulse_model.sv
// Purpose: Pulse source side of the counter, bursts or a free square wave
// Assumes: Clocked from the bench clock; output changes 1 ns after an edge
// Notes: Idle low between bursts, so no stray edge is counted
`timescale 1ns/10ps
module fec_pulse_model (
    input wire logic i_sys_clk,
    input wire logic i_free_run,
    output logic o_pulse
);
    logic burst_pulse = 1'b0;
    logic free_pulse = 1'b0;
    logic [1:0] phase = 2'h0;
    // Quarter-rate square wave, half the fastest rate the input sync keeps
    always @(posedge i_sys_clk) begin
        phase <= phase + 2'h1;
        free_pulse <= #1 i_free_run & phase[1];
    end
    // Slow bursts: each pulse lasts three cycles high, three low
    task automatic send(input int unsigned n);
        repeat (n) begin
            repeat (3) @(posedge i_sys_clk);
            #1 burst_pulse = 1'b1;
            repeat (3) @(posedge i_sys_clk);
            #1 burst_pulse = 1'b0;
        end
    endtask
    assign o_pulse = burst_pulse | free_pulse;
endmodule // fec_pulse_model

// ===== bench/fec_counter_tb.sv
// Purpose: Self-checking bench for the frequency and event counter
// Assumes: Segments a..g in bits 0..6, lit high; blank digit reads as zero
// Notes: Gates shortened; overflow past 99999999 is left to design assertions
`timescale 1ns/10ps
module testbench;
    localparam longint unsigned G_SHORT = 1000;
    localparam longint unsigned G_MID = 10000;
    localparam longint unsigned G_LONG = 44000;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_count_gate = 1'b0;
    logic i_reset_button = 1'b0;
    logic [1:0] i_mode_sel = 2'h0;
    logic free_run = 1'b0;
    logic count_in;
    logic o_freq_mode_indicator;
    logic o_event_indicator;
    logic o_overflow_indicator;
    logic [6:0] o_segments;
    logic [7:0] o_digit_select;
    int fail_count = 0;
    int num_checks = 0;
    logic [31:0] shown;
    longint unsigned gates [1:3] = '{G_SHORT, G_MID, G_LONG};
    logic [31:0] freq_exp [1:3] = '{32'h2, 32'h2, 32'h1};
    always #5 i_sys_clk = ~i_sys_clk;
    fec_pulse_model src (.i_sys_clk(i_sys_clk), .i_free_run(free_run), .o_pulse(count_in));
    fec_counter #(.GATE_SHORT(G_SHORT), .GATE_MID(G_MID), .GATE_LONG(G_LONG), .SCAN_CYC(2)) DUT (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_count_in(count_in), .i_count_gate(i_count_gate),
        .i_reset_button(i_reset_button), .i_mode_sel(i_mode_sel),
        .o_freq_mode_indicator(o_freq_mode_indicator), .o_event_indicator(o_event_indicator),
        .o_overflow_indicator(o_overflow_indicator), .o_segments(o_segments),
        .o_digit_select(o_digit_select));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Checks made %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    function automatic logic [3:0] seg_digit(input logic [6:0] s);
        case (s)
            7'h00, 7'h3f: seg_digit = 4'h0;
            7'h06: seg_digit = 4'h1;
            7'h5b: seg_digit = 4'h2;
            7'h4f: seg_digit = 4'h3;
            7'h66: seg_digit = 4'h4;
            7'h6d: seg_digit = 4'h5;
            7'h7d: seg_digit = 4'h6;
            7'h07: seg_digit = 4'h7;
            7'h7f: seg_digit = 4'h8;
            7'h6f: seg_digit = 4'h9;
            default: seg_digit = 4'hf;
        endcase
    endfunction
    // Walk the scan once; segments and enable share one register stage
    task automatic read_display(output logic [31:0] v);
        int k;
        v = 32'h0;
        for (int i = 0; i < 8; i++) begin
            k = 0;
            while (o_digit_select !== (8'h01 << i) && k < 100) begin
                cycles(1);
                k++;
            end
            if (k == 100) begin
                check({24'h0, o_digit_select}, 32'h1 << i);
                results();
            end
            v[4*i +: 4] = seg_digit(o_segments);
        end
    endtask
    task automatic press_button();
        i_reset_button = 1'b1;
        cycles(4);
        i_reset_button = 1'b0;
        cycles(8);
    endtask
    task automatic set_mode(input logic [1:0] m);
        i_mode_sel = m;
        cycles(6);
        check({31'h0, o_freq_mode_indicator}, {31'h0, m != fec_pkg::SEL_EVENT});
        check({31'h0, o_event_indicator}, {31'h0, m == fec_pkg::SEL_EVENT});
    endtask
    initial begin
        cycles(5);
        check({24'h0, o_digit_select}, 32'h0);
        check({31'h0, o_overflow_indicator}, 32'h0);
        i_rst = 1'b0;
        cycles(4);
        $display("Test reset done");
        // Event counting with the gate opened and closed
        set_mode(fec_pkg::SEL_EVENT);
        press_button();
        i_count_gate = 1'b1;
        src.send(12);
        cycles(10);
        read_display(shown);
        check(shown, 32'h12);
        i_count_gate = 1'b0;
        src.send(5);
        cycles(10);
        read_display(shown);
        check(shown, 32'h12);
        i_count_gate = 1'b1;
        src.send(3);
        cycles(10);
        read_display(shown);
        check(shown, 32'h15);
        press_button();
        read_display(shown);
        check(shown, 32'h0);
        src.send(1);
        cycles(10);
        read_display(shown);
        check(shown, 32'h1);
        check({31'h0, o_overflow_indicator}, 32'h0);
        $display("Test event mode done");
        // Quarter-rate input over each gate; reading dropped to kHz digits
        free_run = 1'b1;
        for (int m = 1; m <= 3; m++) begin
            set_mode(m[1:0]);
            cycles(int'(gates[m]) + 60);
            read_display(shown);
            check(shown, freq_exp[m]);
            check({31'h0, o_overflow_indicator}, 32'h0);
        end
        free_run = 1'b0;
        $display("Test frequency mode done");
        results();
    end
endmodule // testbench
